// ==== logic/fpp_map.svh ====
/*
  Constants of the FIR filter port and precision block: widths, counts,
  register offsets, field positions and reset values.
  Assumes inclusion by its bare name from the package and the top module.
*/
`ifndef FPP_MAP_SVH
`define FPP_MAP_SVH

// ----------------------------------------------------------------------
// data path widths and sizes
// ----------------------------------------------------------------------
`define FPP_DW          16
`define FPP_CW          16
`define FPP_CIW         16
`define FPP_OW          16
`define FPP_TAPS        64
`define FPP_TAPW        6
`define FPP_CH          4
`define FPP_CHW         2
`define FPP_DEC_MAX     4
`define FPP_FACW        3
`define FPP_FULLW       (`FPP_DW + `FPP_CW + `FPP_TAPW)
`define FPP_DROP        15

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define FPP_FACT_WAIT   3'h4

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define FPP_AW          12
`define FPP_OFF_CTRL    12'h000
`define FPP_OFF_STATUS  12'h004
`define FPP_CTRL_RND_LSB 0
`define FPP_ST_READY    0
`define FPP_ST_LOADED   1
`define FPP_ST_BUSY     2
`define FPP_ST_SAT      3
`define FPP_ST_FAC_LSB  4
`define FPP_ST_CH_LSB   8
`define FPP_RST_FACTOR  3'h4
`define FPP_RST_CH      2'h3

`endif

// ==== logic/fpp_pkg.sv ====
/*
  Types of the FIR filter port and precision block.
  Assumes fpp_map.svh on the include path.
*/
`include "fpp_map.svh"

package fpp_pkg;

  // --------------------------------------------------------------------
  // modes and states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    FPP_RND_NONE,
    FPP_RND_UP,
    FPP_RND_AWAY,
    FPP_RND_ZERO,
    FPP_RND_CONV
  } fpp_round_t;

  typedef enum logic [1:0] {
    FPP_ST_IDLE,
    FPP_ST_MAC,
    FPP_ST_OUT,
    FPP_ST_FACT
  } fpp_state_t;

  // --------------------------------------------------------------------
  // stream carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                    valid;
    logic                    bstart;
    logic signed [`FPP_DW-1:0] data;
  } fpp_sample_in_t;

  typedef struct packed {
    logic                    valid;
    logic                    bstart;
    logic signed [`FPP_OW-1:0] data;
  } fpp_sample_out_t;

endpackage

// ==== logic/fpp_filter.sv ====
/*
  FIR filter core: sample stream in and out, reloadable coefficients,
  four channels, run-time decimation factor, rounding output stage and
  an APB slave for the rounding mode and status.
  Assumes upstream and downstream logic on pclk; coefficients loaded
  in plain tap order.
*/
// Summary of operation
// - async active-low reset clears core
// - take sample only when qualifier high
// - output qualifier marks valid output data
// - coefficient strobe writes coefficient memory
// - commit switches to newly loaded set
// - input block start marks channel zero
// - output block start with channel zero
// - factor load adopts new rate factor
// - clock enable low freezes everything but the APB slave and its register writes
// - synchronous clear restores reset values
// - full width derived from data, coefficients, taps
// - cut result to output width, saturate
// - none mode truncates without correction
// - round up: nearest, ties positive
// - ties move away from zero
// - ties move towards zero
// - ties go to nearest even
// - signed symmetric: coefficient bus plus one
// - otherwise coefficient bus equals coefficient width
// - factor change drops ready briefly
// - ready held low until coefficients committed
`timescale 1ns/1ps
`include "fpp_map.svh"

module fpp_filter (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [`FPP_AW-1:0]             paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // sample stream
  input  wire fpp_pkg::fpp_sample_in_t        s_in,
  output logic                                in_ready,
  output fpp_pkg::fpp_sample_out_t            m_out,
  // coefficient reload
  input  wire logic [`FPP_CIW-1:0]            coeff_in,
  input  wire logic                           coeff_we,
  input  wire logic                           coeff_set,
  // rate factor
  input  wire logic [`FPP_FACW-1:0]           factor_in,
  input  wire logic                           factor_set,
  // optional controls
  input  wire logic                           clk_en,
  input  wire logic                           synchronous_clear
);

  // ----------------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------------
  localparam int FW = `FPP_FULLW;
  localparam int TW = FW - `FPP_DROP + 1;

  logic signed [`FPP_DW-1:0]   tap_mem [`FPP_CH*`FPP_TAPS];
  logic signed [`FPP_CW-1:0]   coeff_mem [2*`FPP_TAPS];

  fpp_pkg::fpp_state_t         state;
  fpp_pkg::fpp_round_t         rnd_mode;
  logic [`FPP_TAPW-1:0]        mac_i;
  logic signed [FW-1:0]        acc;
  logic [`FPP_CHW-1:0]         cur_ch;
  logic [`FPP_TAPW-1:0]        wp;
  logic [`FPP_FACW-1:0]        phase;
  logic [`FPP_FACW-1:0]        factor;
  logic [2:0]                  fact_cnt;
  logic                        factor_pend;
  logic                        bank;
  logic                        loaded;
  logic                        commit_pend;
  logic [`FPP_TAPW-1:0]        load_idx;
  logic                        ready_prev;
  logic                        sat_seen;
  logic                        sat_now;

  logic                        run;
  logic                        clr;
  logic                        take;
  logic [`FPP_CHW-1:0]         next_ch;
  logic [`FPP_TAPW-1:0]        next_wp;
  logic [`FPP_FACW-1:0]        next_phase;
  logic signed [2*`FPP_DW-1:0] prod;
  logic [`FPP_OW:0]            rounded;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [`FPP_CHW+`FPP_TAPW-1:0] fpp_addr(
    input logic [`FPP_CHW-1:0]  ch,
    input logic [`FPP_TAPW-1:0] idx
  );
    return {ch, idx};
  endfunction

  // returns {saturated, output word}
  function automatic logic [`FPP_OW:0] fpp_round(
    input logic signed [FW-1:0] a,
    input fpp_pkg::fpp_round_t  m
  );
    logic              tie;
    logic              over;
    logic              up;
    logic signed [TW-1:0] t;
    tie  = a[`FPP_DROP-1] & ~|a[`FPP_DROP-2:0];
    over = a[`FPP_DROP-1] & |a[`FPP_DROP-2:0];
    t    = {a[FW-1], a[FW-1:`FPP_DROP]};
    unique case (m)
      fpp_pkg::FPP_RND_NONE: up = 1'b0;
      fpp_pkg::FPP_RND_UP:   up = tie | over;
      fpp_pkg::FPP_RND_AWAY: up = over | (tie & ~a[FW-1]);
      fpp_pkg::FPP_RND_ZERO: up = over | (tie & a[FW-1]);
      fpp_pkg::FPP_RND_CONV: up = over | (tie & t[0]);
      default:               up = 1'b0;
    endcase
    t = t + TW'(up);
    // overflow saturates rather than wrapping; loud errors beat silent ones
    if (t > $signed(TW'((1 << (`FPP_OW-1)) - 1))) begin
      return {1'b1, 1'b0, {(`FPP_OW-1){1'b1}}};
    end else if (t < -$signed(TW'(1 << (`FPP_OW-1)))) begin
      return {1'b1, 1'b1, {(`FPP_OW-1){1'b0}}};
    end
    return {1'b0, t[`FPP_OW-1:0]};
  endfunction

  // ----------------------------------------------------------------------
  // input acceptance and channel tracking
  // ----------------------------------------------------------------------
  always_comb begin
    run  = clk_en;
    clr  = synchronous_clear;
    // a sample is legal only in the cycle after ready was shown
    take = s_in.valid && ready_prev && (state == fpp_pkg::FPP_ST_IDLE);
    next_ch = s_in.bstart ? '0 : cur_ch + 1'b1;
    next_wp = (next_ch == '0) ? wp + 1'b1 : wp;
    next_phase = phase;
    if (next_ch == '0) begin
      next_phase = (phase + 1'b1 >= factor) ? '0 : phase + 1'b1;
    end
    // zero taps skip the product so unwritten history never reaches a result
    if (coeff_mem[{bank, mac_i}] == '0) begin
      prod = '0;
    end else begin
      prod = coeff_mem[{bank, mac_i}] * tap_mem[fpp_addr(cur_ch, wp - mac_i)];
    end
    rounded = fpp_round(acc, rnd_mode);
    sat_now = rounded[`FPP_OW];
  end

  always_ff @(posedge pclk) begin
    if (run && !clr && take) begin
      tap_mem[fpp_addr(next_ch, next_wp)] <= s_in.data;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer: one multiplier walks all taps per output
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= fpp_pkg::FPP_ST_IDLE;
      mac_i    <= '0;
      acc      <= '0;
      cur_ch   <= `FPP_RST_CH;
      wp       <= '0;
      phase    <= '0;
      fact_cnt <= '0;
    end else if (run) begin
      if (clr) begin
        state    <= fpp_pkg::FPP_ST_IDLE;
        mac_i    <= '0;
        acc      <= '0;
        cur_ch   <= `FPP_RST_CH;
        wp       <= '0;
        phase    <= '0;
        fact_cnt <= '0;
      end else begin
        unique case (state)
          fpp_pkg::FPP_ST_IDLE: begin
            if (take) begin
              cur_ch <= next_ch;
              wp     <= next_wp;
              phase  <= next_phase;
              mac_i  <= '0;
              // samples of a dropped phase only feed the delay line
              if (next_phase == '0) begin
                state <= fpp_pkg::FPP_ST_MAC;
              end
            end else if (factor_pend) begin
              state    <= fpp_pkg::FPP_ST_FACT;
              fact_cnt <= `FPP_FACT_WAIT;
              phase    <= '0;
            end
          end
          fpp_pkg::FPP_ST_MAC: begin
            acc   <= (mac_i == '0) ? FW'(prod) : acc + FW'(prod);
            mac_i <= mac_i + 1'b1;
            if (mac_i == `FPP_TAPW'(`FPP_TAPS - 1)) begin
              state <= fpp_pkg::FPP_ST_OUT;
            end
          end
          fpp_pkg::FPP_ST_OUT: begin
            state <= fpp_pkg::FPP_ST_IDLE;
          end
          fpp_pkg::FPP_ST_FACT: begin
            fact_cnt <= fact_cnt - 1'b1;
            if (fact_cnt == 3'h1) begin
              state <= fpp_pkg::FPP_ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // coefficient reload into the shadow bank
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (run && !clr && coeff_we) begin
      coeff_mem[{~bank, load_idx}] <= coeff_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank        <= 1'b0;
      loaded      <= 1'b0;
      commit_pend <= 1'b0;
      load_idx    <= '0;
    end else if (run) begin
      if (clr) begin
        bank        <= 1'b0;
        loaded      <= 1'b0;
        commit_pend <= 1'b0;
        load_idx    <= '0;
      end else begin
        if (coeff_we) begin
          load_idx <= load_idx + 1'b1;
        end
        if (coeff_set) begin
          commit_pend <= 1'b1;
          load_idx    <= '0;
        end else if (commit_pend && state == fpp_pkg::FPP_ST_IDLE && !take) begin
          // swap only between outputs so no result mixes two sets
          bank        <= ~bank;
          loaded      <= 1'b1;
          commit_pend <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // rate factor and ready
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      factor      <= `FPP_RST_FACTOR;
      factor_pend <= 1'b0;
      in_ready    <= 1'b0;
      ready_prev  <= 1'b0;
    end else if (run) begin
      if (clr) begin
        factor      <= `FPP_RST_FACTOR;
        factor_pend <= 1'b0;
        in_ready    <= 1'b0;
        ready_prev  <= 1'b0;
      end else begin
        if (factor_set) begin
          factor      <= factor_in;
          factor_pend <= 1'b1;
        end else if (state == fpp_pkg::FPP_ST_FACT) begin
          factor_pend <= 1'b0;
        end
        ready_prev <= in_ready;
        // one-cycle ready pulses keep a single sample window open
        in_ready <= (state == fpp_pkg::FPP_ST_IDLE) && loaded && !in_ready
                    && !ready_prev && !factor_pend && !factor_set
                    && !commit_pend && !coeff_set && !take;
      end
    end
  end

  // ----------------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_out <= '0;
    end else if (run) begin
      if (clr) begin
        m_out <= '0;
      end else begin
        m_out.valid <= (state == fpp_pkg::FPP_ST_OUT);
        if (state == fpp_pkg::FPP_ST_OUT) begin
          m_out.bstart <= (cur_ch == '0);
          m_out.data   <= rounded[`FPP_OW-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  logic acc_req;
  logic wr_done;
  logic hit_ctrl;
  logic hit_status;
  logic [31:0] status_word;

  always_comb begin
    acc_req    = psel && penable && !pready;
    wr_done    = psel && penable && pready && pwrite;
    hit_ctrl   = (paddr == `FPP_OFF_CTRL);
    hit_status = (paddr == `FPP_OFF_STATUS);
    status_word = '0;
    status_word[`FPP_ST_READY]  = in_ready;
    status_word[`FPP_ST_LOADED] = loaded;
    status_word[`FPP_ST_BUSY]   = (state != fpp_pkg::FPP_ST_IDLE);
    status_word[`FPP_ST_SAT]    = sat_seen;
    status_word[`FPP_ST_FAC_LSB +: `FPP_FACW] = factor;
    status_word[`FPP_ST_CH_LSB +: `FPP_CHW]   = cur_ch;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc_req;
      pslverr <= acc_req && !hit_ctrl && !hit_status;
      prdata  <= '0;
      if (acc_req && !pwrite && hit_ctrl) begin
        prdata <= {29'h0, rnd_mode};
      end else if (acc_req && !pwrite && hit_status) begin
        prdata <= status_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd_mode <= fpp_pkg::FPP_RND_NONE;
      sat_seen <= 1'b0;
    end else if (run && clr) begin
      rnd_mode <= fpp_pkg::FPP_RND_NONE;
      sat_seen <= 1'b0;
    end else begin
      // writes land on the completing edge only
      if (wr_done && hit_ctrl) begin
        rnd_mode <= fpp_pkg::fpp_round_t'(pwdata[`FPP_CTRL_RND_LSB +: 3]);
      end
      // a clear outranks a saturation; a saturation outranks a w1c
      if (run && state == fpp_pkg::FPP_ST_OUT && sat_now) begin
        sat_seen <= 1'b1;
      end else if (wr_done && hit_status && pwdata[`FPP_ST_SAT]) begin
        sat_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_no_take;
    @(posedge pclk) disable iff (!presetn)
    (run && !clr && state == fpp_pkg::FPP_ST_IDLE && !take) |=> state != fpp_pkg::FPP_ST_MAC;
  endproperty
  a_no_take: assert property (p_no_take) else $error("mac started without a sample");

  property p_out_valid;
    @(posedge pclk) disable iff (!presetn)
    ($rose(m_out.valid) |-> $past(state) == fpp_pkg::FPP_ST_OUT && $past(run))
      and ((m_out.valid && run) |=> !m_out.valid);
  endproperty
  a_out_valid: assert property (p_out_valid) else $error("output valid without a result");

  property p_bstart;
    @(posedge pclk) disable iff (!presetn)
    m_out.valid |-> m_out.bstart == (cur_ch == '0);
  endproperty
  a_bstart: assert property (p_bstart) else $error("block start not on channel zero");

  property p_chan;
    @(posedge pclk) disable iff (!presetn)
    (run && !clr && take && !s_in.bstart) |=> cur_ch == $past(cur_ch) + 2'h1;
  endproperty
  a_chan: assert property (p_chan) else $error("channel did not advance by one");

  property p_ready_loaded;
    @(posedge pclk) disable iff (!presetn)
    !loaded |=> !in_ready;
  endproperty
  a_ready_loaded: assert property (p_ready_loaded) else $error("ready before commit");

  property p_commit;
    @(posedge pclk) disable iff (!presetn)
    (run && !clr && commit_pend && !coeff_set && state == fpp_pkg::FPP_ST_IDLE && !take)
      |=> bank != $past(bank) && loaded;
  endproperty
  a_commit: assert property (p_commit) else $error("commit did not swap bank");

  property p_factor;
    @(posedge pclk) disable iff (!presetn)
    (run && !clr && factor_set) |=> factor == $past(factor_in) ##1 !in_ready;
  endproperty
  a_factor: assert property (p_factor) else $error("factor not adopted");

  property p_fact_ready;
    @(posedge pclk) disable iff (!presetn)
    state == fpp_pkg::FPP_ST_FACT |=> !in_ready;
  endproperty
  a_fact_ready: assert property (p_fact_ready) else $error("ready during factor change");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !run |=> $stable(state) && $stable(acc) && $stable(in_ready) && $stable(m_out);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with clock enable low");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (run && clr) |=> state == fpp_pkg::FPP_ST_IDLE && !in_ready && !loaded && !m_out.valid;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state behind");

endmodule

// ==== tb/fpp_stream_partner.sv ====
/*
  Stream partner of the filter: sample source and sample consumer.
  Assumes the filter on the same pclk; the bench calls the tasks.
*/
`timescale 1ns/1ps
`include "fpp_map.svh"

module fpp_stream_partner (
  // clock
  input  wire logic                     pclk,
  // filter side
  input  wire logic                     in_ready,
  input  wire fpp_pkg::fpp_sample_out_t m_out,
  output fpp_pkg::fpp_sample_in_t       s_in
);

  initial s_in = '0;

  // ----------------------------------------------------------------
  // source
  // ----------------------------------------------------------------
  task automatic send(input logic [`FPP_DW-1:0] d, input logic mark);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (in_ready !== 1'b1 && n < 3000);
    s_in <= '{valid: 1'b1, bstart: mark, data: d};
    @(posedge pclk);
    // idle data inverted so a stale capture shows up
    s_in <= '{valid: 1'b0, bstart: 1'b0, data: ~d};
  endtask

  // qualified sample without a ready cycle before it
  task automatic stray(input logic [`FPP_DW-1:0] d);
    s_in <= '{valid: 1'b1, bstart: 1'b1, data: d};
    @(posedge pclk);
    s_in <= '{valid: 1'b0, bstart: 1'b0, data: ~d};
  endtask

  // ----------------------------------------------------------------
  // consumer
  // ----------------------------------------------------------------
  task automatic recv(output logic [`FPP_DW-1:0] d, output logic mark, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (m_out.valid !== 1'b1 && n < 400);
    d = m_out.data;
    mark = m_out.bstart;
  endtask

endmodule

// ==== tb/fpp_filter_tb.sv ====
/*
  Self-checking bench of the filter: APB master, coefficient loader,
  stream partner. Assumes a single-tap coefficient set, so each
  output is the current sample scaled, which makes rounding visible.
*/
`timescale 1ns/1ps
`include "fpp_map.svh"

module fpp_filter_tb;

  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [`FPP_AW-1:0]        paddr = '0;
  logic [31:0]               pwdata = '0;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  fpp_pkg::fpp_sample_in_t   s_in;
  logic                      in_ready;
  fpp_pkg::fpp_sample_out_t  m_out;
  logic [`FPP_CIW-1:0]       coeff_in = '0;
  logic                      coeff_we = 1'b0;
  logic                      coeff_set = 1'b0;
  logic [`FPP_FACW-1:0]      factor_in = '0;
  logic                      factor_set = 1'b0;
  logic                      clk_en = 1'b1;
  logic                      synchronous_clear = 1'b0;
  int                        err_total = 0;
  int                        n_compared = 0;
  logic [31:0]               rd;
  logic                      er;
  logic [15:0]               od;
  logic                      ob;
  int                        lat;
  logic                      seen;
  logic [15:0]               exp_p5 [5] = '{16'h0002, 16'h0003, 16'h0003, 16'h0002, 16'h0002};
  logic [15:0]               exp_m3 [5] = '{16'hfffe, 16'hffff, 16'hfffe, 16'hffff, 16'hfffe};

  always #10 pclk = ~pclk;

  fpp_filter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .s_in(s_in), .in_ready(in_ready), .m_out(m_out),
    .coeff_in(coeff_in), .coeff_we(coeff_we), .coeff_set(coeff_set),
    .factor_in(factor_in), .factor_set(factor_set), .clk_en(clk_en),
    .synchronous_clear(synchronous_clear));

  fpp_stream_partner u_src (.pclk(pclk), .in_ready(in_ready), .m_out(m_out), .s_in(s_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic load(input logic [15:0] c0);
    for (int i = 0; i < `FPP_TAPS; i++) begin
      @(posedge pclk);
      coeff_we <= 1'b1;
      coeff_in <= (i == 0) ? c0 : 16'h0000;
    end
    @(posedge pclk);
    coeff_we <= 1'b0;
    coeff_in <= 16'h5a5a;
    coeff_set <= 1'b1;
    @(posedge pclk);
    coeff_set <= 1'b0;
  endtask

  task automatic sample(input logic [15:0] x, input logic mk, input logic [15:0] ed,
                        input logic eb);
    u_src.send(x, mk);
    u_src.recv(od, ob, lat);
    check(32'(lat), 32'h42);
    check({16'h0, od}, {16'h0, ed});
    check({31'h0, ob}, {31'h0, eb});
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({13'h0, m_out, in_ready}, 32'h0);
    apb(1'b0, `FPP_OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0340);
    apb(1'b0, 12'h008, 32'h0);
    check({31'h0, er}, 32'h1);
    seen = 1'b0;
    repeat (100) begin
      @(posedge pclk);
      seen = seen | in_ready;
    end
    check({31'h0, seen}, 32'h0);
    load(16'h4000);
    apb(1'b0, `FPP_OFF_STATUS, 32'h0);
    check({31'h0, rd[`FPP_ST_LOADED]}, 32'h1);
    factor_in <= 3'h1;
    factor_set <= 1'b1;
    @(posedge pclk);
    factor_set <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      seen = seen | in_ready;
    end
    check({31'h0, seen}, 32'h0);
    apb(1'b0, `FPP_OFF_STATUS, 32'h0);
    check({29'h0, rd[6:4]}, 32'h1);
    // five modes, a positive and a negative half each; channels wrap
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, `FPP_OFF_CTRL, 32'(m));
      apb(1'b0, `FPP_OFF_CTRL, 32'h0);
      check(rd, 32'(m));
      sample(16'h0005, m == 0, exp_p5[m], (m % 2) == 0);
      sample(16'hfffd, 1'b0, exp_m3[m], 1'b0);
    end
    // clock enable low mid-run, stray sample meanwhile
    u_src.send(16'h0005, 1'b0);
    repeat (5) @(posedge pclk);
    clk_en <= 1'b0;
    u_src.stray(16'h0064);
    repeat (9) @(posedge pclk);
    clk_en <= 1'b1;
    u_src.recv(od, ob, lat);
    check(32'(lat), 32'h3d);
    check({15'h0, ob, od}, 32'h0000_0002);
    load(16'h2000);
    sample(16'h0008, 1'b1, 16'h0002, 1'b1);
    // most negative squared overflows by one step
    load(16'h8000);
    sample(16'h8000, 1'b1, 16'h7fff, 1'b1);
    apb(1'b0, `FPP_OFF_STATUS, 32'h0);
    check({31'h0, rd[`FPP_ST_SAT]}, 32'h1);
    apb(1'b1, `FPP_OFF_STATUS, 32'h8);
    apb(1'b0, `FPP_OFF_STATUS, 32'h0);
    check({31'h0, rd[`FPP_ST_SAT]}, 32'h0);
    apb(1'b1, `FPP_OFF_CTRL, 32'h3);
    @(posedge pclk);
    synchronous_clear <= 1'b1;
    @(posedge pclk);
    synchronous_clear <= 1'b0;
    apb(1'b0, `FPP_OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `FPP_OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0340);
    load(16'h4000);
    u_src.send(16'h0005, 1'b1);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    seen = 1'b0;
    repeat (80) begin
      @(posedge pclk);
      seen = seen | m_out.valid | in_ready;
    end
    check({31'h0, seen}, 32'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    summarize();
  end

endmodule
